// ==== rtl/bst_defines.svh ====
`ifndef BST_DEFINES_SVH
`define BST_DEFINES_SVH
// Instruction register width and its codes.
`define BST_IR_W 3
`define BST_IR_EXTEST 3'h0
`define BST_IR_IDCODE 3'h1
`define BST_IR_SAMPLEZ 3'h2
`define BST_IR_SAMPLE 3'h4
`define BST_IR_BYPASS 3'h7
// Scan chain lengths; the boundary chain ends in one internal cell.
`define BST_BSR_LEN 129
`define BST_ID_LEN 32
// Value that the internal boundary cell always captures.
`define BST_INT_CELL_CAP 1'h1
// Consecutive high test-mode edges that always end in Test-Logic-Reset.
`define BST_ONES_TO_RESET 3'h5
// Register map, byte offsets decoded from the low address bits.
`define BST_ADDR_W 8
`define BST_OFS_CTRL 8'h00
`define BST_OFS_STATUS 8'h04
`define BST_OFS_IDCODE 8'h08
// Control register fields and reset value of the termination enable.
`define BST_CTRL_ODT_BIT 0
`define BST_CTRL_SRST_BIT 1
`define BST_CTRL_ODT_RST 1'h1
// Bus transfer type bit that marks NONSEQ or SEQ.
`define BST_HTRANS_ACT_BIT 1
`endif

// ==== rtl/bst_pkg.sv ====
package bst_pkg;
    // The three test pins that arrive from the tester.
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bst_jtag_in_t;
    // Controller states; codes follow declaration order from TLR = 0.
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } bst_tap_state_t;
    // Data register placed in the serial path.
    typedef enum logic [1:0] {DR_BSR, DR_ID, DR_BYP} bst_dr_sel_t;
    // Layout of the read-only status word.
    typedef struct packed {
        logic [23:0] rsvd;
        logic tdo_oe;
        logic [2:0] instr;
        logic [3:0] state;
    } bst_status_t;
    // Bus address phase held over into its data phase.
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } bst_ahb_req_t;
endpackage

// ==== rtl/bst_tap.sv ====
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "bst_defines.svh"
module bst_tap #(
    parameter int Q_W = 36, // Read data pins under boundary control.
    parameter logic [31:0] ID_CODE = 32'h0000_0001 // Arbitrary value; bit 0 must stay set.
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire bst_pkg::bst_jtag_in_t jtag_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    input wire logic [`BST_BSR_LEN-2:0] io_ring_i,
    input wire logic [Q_W-1:0] func_q_i,
    input wire logic func_q_oe_i,
    input wire logic func_valid_i,
    input wire logic [1:0] func_echo_i,
    output logic [Q_W-1:0] q_o,
    output logic q_oe_o,
    output logic read_valid_strobe_o,
    output logic [1:0] echo_clock_out_o,
    output logic on_die_termination_o,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o
);
    import bst_pkg::*;

    // Pin synchronisers and the delayed clock level for edge finding.
    bst_jtag_in_t jtag_s1_ff, jtag_s2_ff;
    logic tck_d_ff;
    logic tck_rise, tck_fall;
    // Controller, instruction and data register state.
    bst_tap_state_t state_ff, nxt_state;
    logic [`BST_IR_W-1:0] ir_sr_ff, nxt_ir_sr; // Instruction shift stage.
    logic [`BST_IR_W-1:0] ir_ff, nxt_ir; // Instruction in effect.
    logic [`BST_BSR_LEN-1:0] dr_ff, nxt_dr; // Shared data shift stage.
    logic [`BST_BSR_LEN-1:0] upd_ff, nxt_upd; // Boundary update latches.
    logic tdo_ff, nxt_tdo, oe_ff, nxt_oe;
    logic [2:0] ones_ff, nxt_ones; // Run of high test-mode edges.
    bst_dr_sel_t dr_sel;
    // Bus side state.
    bst_ahb_req_t req_ff, nxt_req;
    logic odt_ff, nxt_odt, srst_ff, nxt_srst;
    logic [31:0] rdata_ff, nxt_rdata;
    bst_status_t status;
    logic extest, samplez;

    // Standard controller transitions on the sampled test-mode level.
    function automatic bst_tap_state_t tap_next(input bst_tap_state_t s, input logic m);
        unique case (s)
            TLR: return m ? TLR : RTI;
            RTI: return m ? SEL_DR : RTI;
            SEL_DR: return m ? SEL_IR : CAP_DR;
            CAP_DR: return m ? EX1_DR : SH_DR;
            SH_DR: return m ? EX1_DR : SH_DR;
            EX1_DR: return m ? UPD_DR : PAU_DR;
            PAU_DR: return m ? EX2_DR : PAU_DR;
            EX2_DR: return m ? UPD_DR : SH_DR;
            UPD_DR: return m ? SEL_DR : RTI;
            SEL_IR: return m ? TLR : CAP_IR;
            CAP_IR: return m ? EX1_IR : SH_IR;
            SH_IR: return m ? EX1_IR : SH_IR;
            EX1_IR: return m ? UPD_IR : PAU_IR;
            PAU_IR: return m ? EX2_IR : PAU_IR;
            EX2_IR: return m ? UPD_IR : SH_IR;
            UPD_IR: return m ? SEL_DR : RTI;
        endcase
    endfunction

    // Two flops per pin; only the second stage feeds any logic.
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            jtag_s1_ff <= '0;
            jtag_s2_ff <= '0;
            tck_d_ff <= '0;
        end else begin
            jtag_s1_ff <= jtag_i;
            jtag_s2_ff <= jtag_s1_ff;
            tck_d_ff <= jtag_s2_ff.tck;
        end
    end

    // The test clock is sampled, so it must stay well below the core rate.
    assign tck_rise = jtag_s2_ff.tck & ~tck_d_ff;
    assign tck_fall = ~jtag_s2_ff.tck & tck_d_ff;

    // Which data register the instruction in effect selects.
    always_comb begin
        unique case (ir_ff)
            `BST_IR_EXTEST, `BST_IR_SAMPLEZ, `BST_IR_SAMPLE: dr_sel = DR_BSR;
            `BST_IR_IDCODE: dr_sel = DR_ID;
            default: dr_sel = DR_BYP;
        endcase
    end

    // Next values of the controller and its scan registers.
    always_comb begin
        nxt_state = state_ff;
        nxt_ir_sr = ir_sr_ff;
        nxt_ir = ir_ff;
        nxt_dr = dr_ff;
        nxt_upd = upd_ff;
        nxt_tdo = tdo_ff;
        nxt_oe = oe_ff;
        nxt_ones = ones_ff;
        if (srst_ff) begin
            // Software reset of the controller wins over any test-clock edge.
            nxt_state = TLR;
            nxt_oe = 1'b0;
            nxt_ones = '0;
        end else if (tck_rise) begin
            // State moves on the rise only.
            nxt_state = tap_next(state_ff, jtag_s2_ff.tms);
            if (!jtag_s2_ff.tms) begin
                nxt_ones = '0;
            end else if (ones_ff != `BST_ONES_TO_RESET) begin
                nxt_ones = ones_ff + 3'h1;
            end
            if (state_ff == CAP_IR) begin
                nxt_ir_sr = `BST_IR_IDCODE;
            end else if (state_ff == SH_IR) begin
                nxt_ir_sr = {jtag_s2_ff.tdi, ir_sr_ff[`BST_IR_W-1:1]};
            end else if (state_ff == CAP_DR) begin
                unique case (dr_sel)
                    DR_BSR: nxt_dr = {`BST_INT_CELL_CAP, io_ring_i};
                    DR_ID: nxt_dr = `BST_BSR_LEN'(ID_CODE);
                    default: nxt_dr = '0;
                endcase
            end else if (state_ff == SH_DR) begin
                nxt_dr = dr_ff >> 1;
                unique case (dr_sel)
                    DR_BSR: nxt_dr[`BST_BSR_LEN-1] = jtag_s2_ff.tdi;
                    DR_ID: nxt_dr[`BST_ID_LEN-1] = jtag_s2_ff.tdi;
                    default: nxt_dr[0] = jtag_s2_ff.tdi;
                endcase
            end
        end else if (tck_fall) begin
            nxt_oe = (state_ff == SH_IR) || (state_ff == SH_DR);
            nxt_tdo = (state_ff == SH_IR) ? ir_sr_ff[0] : dr_ff[0];
            if (state_ff == UPD_IR) begin
                nxt_ir = ir_sr_ff;
            end
            if (state_ff == UPD_DR && dr_sel == DR_BSR) begin
                nxt_upd = dr_ff;
            end
        end
        if (nxt_state == TLR) begin
            nxt_ir = `BST_IR_IDCODE;
            nxt_ir_sr = `BST_IR_IDCODE;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_ff <= TLR;
            ir_sr_ff <= `BST_IR_IDCODE;
            ir_ff <= `BST_IR_IDCODE;
            dr_ff <= '0;
            upd_ff <= '0;
            tdo_ff <= '0;
            oe_ff <= '0;
            ones_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            ir_sr_ff <= nxt_ir_sr;
            ir_ff <= nxt_ir;
            dr_ff <= nxt_dr;
            upd_ff <= nxt_upd;
            tdo_ff <= nxt_tdo;
            oe_ff <= nxt_oe;
            ones_ff <= nxt_ones;
        end
    end

    // Status snapshot; reserved bits read as zero.
    always_comb begin
        status = '0;
        status.state = state_ff;
        status.instr = ir_ff;
        status.tdo_oe = oe_ff;
    end

    // Bus slave: zero wait states, one register word per aligned address.
    always_comb begin
        nxt_req.valid = hsel_i & htrans_i[`BST_HTRANS_ACT_BIT] & hready_i;
        nxt_req.write = hwrite_i;
        nxt_req.addr = haddr_i[`BST_ADDR_W-1:0];
        nxt_odt = odt_ff;
        nxt_srst = 1'b0;
        nxt_rdata = '0;
        if (req_ff.valid && req_ff.write && req_ff.addr == `BST_OFS_CTRL) begin
            // Write data arrives in the data phase; reset bit is a pulse.
            nxt_odt = hwdata_i[`BST_CTRL_ODT_BIT];
            nxt_srst = hwdata_i[`BST_CTRL_SRST_BIT];
        end
        if (nxt_req.valid && !hwrite_i) begin
            // Forwarding the pending write keeps back-to-back reads coherent.
            unique case (nxt_req.addr)
                `BST_OFS_CTRL: nxt_rdata = 32'(nxt_odt);
                `BST_OFS_STATUS: nxt_rdata = status;
                `BST_OFS_IDCODE: nxt_rdata = ID_CODE;
                default: nxt_rdata = '0;
            endcase
        end
    end

    // Bus registers.
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            req_ff <= '0;
            odt_ff <= `BST_CTRL_ODT_RST;
            srst_ff <= '0;
            rdata_ff <= '0;
        end else begin
            req_ff <= nxt_req;
            odt_ff <= nxt_odt;
            srst_ff <= nxt_srst;
            rdata_ff <= nxt_rdata;
        end
    end

    assign hrdata_o = rdata_ff;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign tdo_o = tdo_ff;
    assign tdo_oe_o = oe_ff;

    // Pin steering: EXTEST drives from the update cells, termination off; SAMPLEZ turns read drivers and termination off; else core and control register.
    assign extest = (ir_ff == `BST_IR_EXTEST);
    assign samplez = (ir_ff == `BST_IR_SAMPLEZ);
    assign q_o = extest ? upd_ff[Q_W-1:0] : func_q_i;
    assign read_valid_strobe_o = extest ? upd_ff[Q_W] : func_valid_i;
    assign echo_clock_out_o = extest ? upd_ff[Q_W+2:Q_W+1] : func_echo_i;
    assign q_oe_o = samplez ? 1'b0 : (extest ? upd_ff[`BST_BSR_LEN-1] : func_q_oe_i);
    assign on_die_termination_o = odt_ff & ~(extest | samplez);

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    tlr_five_ones_a: assert property (
        ones_ff == `BST_ONES_TO_RESET |-> state_ff == TLR)
        else $error("Five high edges did not reach reset.");
    tdi_ignored_a: assert property (
        tck_rise && !srst_ff && state_ff inside {RTI, SEL_DR, EX1_DR, PAU_DR, EX2_DR,
        UPD_DR, EX1_IR, PAU_IR, EX2_IR, UPD_IR} |=> $stable(dr_ff) && $stable(ir_sr_ff))
        else $error("Scan register moved outside shift.");
    tdo_enable_a: assert property (
        $rose(tdo_oe_o) |-> state_ff inside {SH_IR, SH_DR})
        else $error("Output driver enabled outside shift.");
    tdo_fall_a: assert property (
        tck_fall && !srst_ff && state_ff == SH_DR |=> tdo_o == $past(dr_ff[0]))
        else $error("Output bit not presented on fall.");
    ir_capture_a: assert property (
        tck_rise && !srst_ff && state_ff == CAP_IR |=> ir_sr_ff == `BST_IR_IDCODE)
        else $error("Capture-IR did not load identify code.");
    ir_update_a: assert property (
        $changed(ir_ff) |-> $past(state_ff) == UPD_IR || state_ff == TLR)
        else $error("Instruction changed outside update.");
    bsr_capture_a: assert property (
        tck_rise && !srst_ff && state_ff == CAP_DR && dr_sel == DR_BSR
        |=> dr_ff == {`BST_INT_CELL_CAP, $past(io_ring_i)})
        else $error("Boundary capture wrong.");
    id_capture_a: assert property (
        tck_rise && !srst_ff && state_ff == CAP_DR && dr_sel == DR_ID
        |=> dr_ff[`BST_ID_LEN-1:0] == ID_CODE)
        else $error("Identification capture wrong.");
    bypass_capture_a: assert property (
        tck_rise && !srst_ff && state_ff == CAP_DR && dr_sel == DR_BYP |=> !dr_ff[0])
        else $error("Bypass did not capture zero.");
    samplez_float_a: assert property (
        ir_ff == `BST_IR_SAMPLEZ |-> !q_oe_o)
        else $error("Read drivers on under sample-z.");
    odt_off_a: assert property (
        ir_ff inside {`BST_IR_EXTEST, `BST_IR_SAMPLEZ} |-> !on_die_termination_o)
        else $error("Termination on during test.");
    extest_pins_a: assert property (
        extest && $changed({q_oe_o, echo_clock_out_o, read_valid_strobe_o, q_o})
        |-> $past(state_ff) == UPD_DR || $changed(ir_ff))
        else $error("External test pins changed outside update.");
endmodule

// ==== testbench/bst_tester.sv ====
`timescale 1ns/1ps
// Behavioural test controller on the far side of the test port.
module bst_tester (
    input wire logic core_clk_i,
    input wire logic tdo_i,
    input wire logic tdo_oe_i,
    output bst_pkg::bst_jtag_in_t jtag_o
);
    import bst_pkg::*;
    // A released output is pulled high, so a stale bit cannot pass for data.
    logic tdo_line;
    assign tdo_line = tdo_oe_i ? tdo_i : 1'b1;
    // The test clock parks low between frames; data idles high and mode starts high.
    initial jtag_o = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
    // One 160 ns test clock: set up on the low half, sample before the rise.
    task automatic bit_cyc(input logic tms, input logic tdi, output logic tdo);
        @(posedge core_clk_i);
        jtag_o.tms <= tms;
        jtag_o.tdi <= tdi;
        // Seven here plus the entry edge gives eight low cycles, so the period is 160 ns.
        repeat (7) @(posedge core_clk_i);
        tdo = tdo_line;
        jtag_o.tck <= 1'b1;
        repeat (8) @(posedge core_clk_i);
        jtag_o.tck <= 1'b0;
    endtask
    task automatic tap_reset;
        logic d;
        repeat (5) bit_cyc(1'b1, 1'b1, d);
        bit_cyc(1'b0, 1'b1, d);
    endtask
    // codes chosen by caller
    // From idle, walks one scan of n bits and returns to idle after update.
    task automatic shift(input logic ir, input int n, input logic [159:0] din,
                         output logic [159:0] dout);
        logic d;
        dout = '0;
        bit_cyc(1'b1, 1'b1, d);
        if (ir) begin
            bit_cyc(1'b1, 1'b1, d);
        end
        bit_cyc(1'b0, 1'b1, d);
        bit_cyc(1'b0, 1'b1, d);
        for (int i = 0; i < n; i++) begin
            bit_cyc(i == n - 1, din[i], dout[i]);
        end
        bit_cyc(1'b1, 1'b1, d);
        bit_cyc(1'b0, 1'b1, d);
    endtask
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
    import bst_pkg::*;
    // Arbitrary identification value for the bench; bit 0 must stay set.
    localparam logic [31:0] ID_VAL = 32'h2468_ace1;
    localparam logic [127:0] RING = 128'h0123_4567_89ab_cdef_0f0f_f0f0_a5a5_5a5a;
    logic clk = 1'b0;
    logic rst = 1'b1;
    bst_jtag_in_t jtag;
    logic tdo, tdo_oe, q_oe, vld, on_die_termination, hreadyout, hresp, foe = 1'b1, fval = 1'b0;
    logic hwrite = 1'b0, hsel = 1'b0;
    logic [127:0] ring = '0;
    logic [35:0] q, fq = 36'h9_8765_4321;
    logic [1:0] echo, fecho = 2'h2, htrans = 2'h0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [159:0] dout, p;
    logic [2:0] codes [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
    int n_mismatch = 0;
    int n_checks = 0;
    always #5 clk = ~clk;
    bst_tap #(.Q_W(36), .ID_CODE(ID_VAL)) dut_u (
        .core_clk_i(clk), .sys_rst_i(rst), .jtag_i(jtag), .tdo_o(tdo),
        .tdo_oe_o(tdo_oe), .io_ring_i(ring), .func_q_i(fq), .func_q_oe_i(foe),
        .func_valid_i(fval), .func_echo_i(fecho), .q_o(q), .q_oe_o(q_oe),
        .read_valid_strobe_o(vld), .echo_clock_out_o(echo),
        .on_die_termination_o(on_die_termination), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
        .hresp_o(hresp));
    bst_tester tst_u (.core_clk_i(clk), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .jtag_o(jtag));
    // Prints the verdict and stops.
    task automatic complete_run;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Compares one value against its expectation.
    task automatic check(input logic [159:0] seen, input logic [159:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Waits for the slave to accept, bounded so a hang ends the run.
    task automatic wait_rdy;
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) begin
            n_mismatch++;
            complete_run();
        end
    endtask
    // One single bus transfer: address phase, then data phase.
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask
    // Cuts a hung run short.
    initial begin
        #500us;
        n_mismatch++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        ahb(1'b0, 8'h04, '0);
        check(rd, 32'h10);
        ahb(1'b0, 8'h08, '0);
        check(rd, ID_VAL);
        ahb(1'b0, 8'h0c, '0);
        check(rd, 32'h0);
        check({hresp, hreadyout}, 2'h1);
        tst_u.tap_reset();
        // Identification leaves LSB first; the input follows it out.
        tst_u.shift(1'b0, 64, 160'h0f1e_2d3c, dout);
        check(dout[63:0], {32'h0f1e_2d3c, ID_VAL});
        // Bypass and the reserved codes all give a one-bit path.
        foreach (codes[i]) begin
            tst_u.shift(1'b1, 3, {157'h0, codes[i]}, dout);
            check(dout[2:0], 3'h1);
            ahb(1'b0, 8'h04, '0);
            check(rd, {25'h0, codes[i], 4'h1});
            tst_u.shift(1'b0, 8, 160'hb5, dout);
            check(dout[7:0], 8'h6a);
            check({on_die_termination, q_oe}, 2'h3);
        end
        ring <= RING;
        tst_u.shift(1'b1, 3, 160'h4, dout);
        tst_u.shift(1'b0, 129, '0, dout);
        check(dout[128:0], {1'b1, RING});
        check(on_die_termination, 1'b1);
        tst_u.shift(1'b1, 3, 160'h2, dout);
        check({on_die_termination, q_oe}, 2'h0);
        tst_u.shift(1'b1, 3, 160'h0, dout);
        // Driven pins follow the update cells; cell 129 gates the drivers.
        for (int j = 0; j < 2; j++) begin
            p = {31'h0, j[0], j[0] ? ~RING : RING};
            tst_u.shift(1'b0, 129, p, dout);
            check(dout[128:0], {1'b1, RING});
            check({q_oe, echo, vld, q}, {p[128], p[38:0]});
            check(on_die_termination, 1'b0);
        end
        // A soft reset returns the controller to its reset state.
        ahb(1'b1, 8'h00, 32'h2);
        ahb(1'b0, 8'h00, '0);
        check(rd, 32'h0);
        ahb(1'b0, 8'h04, '0);
        check(rd, 32'h10);
        check({on_die_termination, q, q_oe}, {1'b0, fq, foe});
        ahb(1'b1, 8'h00, 32'h1);
        // The soft reset left the controller parked in reset; walk it to idle first.
        tst_u.tap_reset();
        tst_u.shift(1'b1, 3, 160'h7, dout);
        ahb(1'b0, 8'h04, '0);
        check(rd, 32'h71);
        tst_u.tap_reset();
        ahb(1'b0, 8'h04, '0);
        check(rd, 32'h11);
        check({on_die_termination, tdo_oe}, 2'h2);
        complete_run();
    end
endmodule
